// *** design/pewr_pkg.sv ***
package pewr_pkg;

  // Record layout, byte offsets from the start of one record
  localparam logic [7:0] REC_BP_OFF = 8'h40;
  localparam logic [7:0] REC_SP_OFF = 8'h48;
  localparam logic [7:0] REC_X1_OFF = 8'h50;
  localparam logic [7:0] REC_GSTAT_OFF = 8'h90;
  localparam logic [7:0] REC_DLA_OFF = 8'h98;
  localparam logic [7:0] REC_DSRC_OFF = 8'ha0;
  localparam logic [7:0] REC_LAT_OFF = 8'ha8;

  // Record lengths, basic and enhanced format
  localparam logic [7:0] REC_LEN_BASIC = 8'h90;
  localparam logic [7:0] REC_LEN_ENH = 8'hb0;

  // Slot order of the writer and last slot of each format
  localparam int SLOT_NUM = 7;
  localparam logic [2:0] SLOT_LAST_BASIC = 3'h2;
  localparam logic [2:0] SLOT_LAST_ENH = 3'h6;
  localparam logic [7:0] REC_SLOT_OFF [0:SLOT_NUM-1] = '{
    REC_BP_OFF, REC_SP_OFF, REC_X1_OFF, REC_GSTAT_OFF,
    REC_DLA_OFF, REC_DSRC_OFF, REC_LAT_OFF};

  // Capability word format field
  localparam int CAP_FMT_LSB = 8;
  localparam logic [3:0] CAP_FMT_ENH = 4'h1;
  localparam logic [3:0] CAP_FMT_BASIC = 4'h0;

  // Global overflow status, buffer overflow bit position
  localparam int GSTAT_BUFOVF_BIT = 62;

  // Register byte offsets on the bus
  localparam logic [7:0] REG_ENABLE = 8'h00;
  localparam logic [7:0] REG_CAP = 8'h04;
  localparam logic [7:0] REG_GSTAT_LO = 8'h08;
  localparam logic [7:0] REG_GSTAT_HI = 8'h0c;
  localparam logic [7:0] REG_BASE = 8'h10;
  localparam logic [7:0] REG_INDEX = 8'h14;
  localparam logic [7:0] REG_ABSMAX = 8'h18;
  localparam logic [7:0] REG_THRESH = 8'h1c;
  localparam logic [7:0] REG_STATUS = 8'h20;

  // Reset values
  localparam logic [31:0] RST_ADDR = 32'h0000_0000;
  localparam logic [63:0] RST_WORD = 64'h0;

  // Writer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_WRITE = 2'b10,
    ST_ADV = 2'b11
  } pewr_state_e;

endpackage

// *** design/pewr_slot_fit.sv ***
// Widens or zeroes one saved register by operating mode
module pewr_slot_fit
  import pewr_pkg::*;
#(
  parameter bit LEGACY_EXISTS = 1'b1
)(
  // Mode and value
  input wire logic long_mode,
  input wire logic [63:0] value,
  // Slot content
  output logic [63:0] slot
);

  // Full width in long mode, low half otherwise, zero if absent
  assign slot = long_mode ? value :
                LEGACY_EXISTS ? {32'h0, value[31:0]} :
                64'h0;

endmodule

// *** design/pewr_sticky.sv ***
// Sticky flag bank, a set in the clear cycle wins
module pewr_sticky #(
  parameter int W = 5
)(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Set and clear strobes
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  // Flags
  output logic [W-1:0] q
);

  logic [W-1:0] q_r;

  // Clear first, then set on top
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      q_r <= '0;
    else
      q_r <= (q_r & ~clr) | set;
  end

  assign q = q_r;

endmodule

// *** design/pewr_top.sv ***
// Functional notes
// - Base pointer, stack pointer and first extended register go to 40H, 48H, 50H; address 98H, source A0H, latency A8H.
// - In long 64-bit mode each saved register is stored with all 64 bits.
// - Outside long mode base pointer, stack pointer and address are stored as 32 bits with bits 63:32 zero; source and latency keep all 64 bits.
// - Outside long mode a slot whose register does not exist is written as zero.
// - The capability word reports 0001B in bits 11:8 when the enhanced tail 90H..AFH is supported.
// - Bytes 97H:90H hold the global overflow status as it stood before the assist began.
// - That snapshot carries every counter's overflow flag, precise or not.
// - Only events flagged precise can start a record write.
// - After a record the index advances one record; none is written at the absolute maximum, silently.
// - When the advanced index reaches the threshold, the interrupt fires and buffer overflow is set.
module pewr_top
  import pewr_pkg::*;
#(
  parameter int NCNT = 4,
  parameter int CIW = 2,
  parameter bit ENHANCED = 1'b1
)(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Core event side
  input wire logic core_long_mode,
  input wire logic [NCNT-1:0] ctr_overflow,
  input wire logic evt_valid,
  input wire logic evt_is_precise,
  input wire logic [CIW-1:0] evt_counter,
  // Core register values at the event
  input wire logic [63:0] base_pointer_register,
  input wire logic [63:0] stack_pointer_register,
  input wire logic [63:0] first_extended_register,
  input wire logic [63:0] data_linear_addr,
  input wire logic [63:0] data_source,
  input wire logic [63:0] load_latency,
  // Memory write port
  output logic mem_req,
  output logic [31:0] mem_addr,
  output logic [63:0] mem_wdata,
  input wire logic mem_ready,
  // Status
  output logic perf_irq,
  output logic assist_busy
);

  pewr_state_e state_r, state_nxt;
  logic [NCNT-1:0] precise_sampling_enable_r;
  logic [31:0] base_r, index_r, absmax_r, thresh_r;
  logic [31:0] hrdata_r;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [2:0] slot_r;
  logic [63:0] slot_data_r [0:SLOT_NUM-1];
  logic long_r;
  logic mem_req_r, perf_irq_r, busy_r;
  logic [31:0] mem_addr_r;
  logic [63:0] mem_wdata_r;
  logic [NCNT:0] gstat_q;

  // Capability word, format field set by the build option
  wire [3:0] cap_fmt = ENHANCED ? CAP_FMT_ENH : CAP_FMT_BASIC;
  wire [31:0] perf_capability_word = {20'h0, cap_fmt, 8'h0};
  wire enh = (cap_fmt == CAP_FMT_ENH);
  wire [2:0] slot_last = enh ? SLOT_LAST_ENH : SLOT_LAST_BASIC;
  wire [7:0] rec_len = enh ? REC_LEN_ENH : REC_LEN_BASIC;

  // Bus address phase decode
  wire addr_phase = hsel && htrans[1] && hready;
  wire rd_take = addr_phase && !hwrite;
  wire wr_take = addr_phase && hwrite;
  wire [7:0] ra = haddr[7:0];

  // Data phase write strobes
  wire w_en = wr_pend_r && (wr_addr_r == REG_ENABLE);
  wire w_glo = wr_pend_r && (wr_addr_r == REG_GSTAT_LO);
  wire w_ghi = wr_pend_r && (wr_addr_r == REG_GSTAT_HI);
  wire w_base = wr_pend_r && (wr_addr_r == REG_BASE);
  wire w_idx = wr_pend_r && (wr_addr_r == REG_INDEX);
  wire w_max = wr_pend_r && (wr_addr_r == REG_ABSMAX);
  wire w_thr = wr_pend_r && (wr_addr_r == REG_THRESH);

  // Global overflow status as a 64-bit word
  wire [63:0] gstat64 = {1'b0, gstat_q[NCNT], {(62-NCNT){1'b0}}, gstat_q[NCNT-1:0]};

  // Read mux, unmapped offsets read zero
  wire [31:0] rd_mux =
    (ra == REG_ENABLE) ? {{(32-NCNT){1'b0}}, precise_sampling_enable_r} :
    (ra == REG_CAP) ? perf_capability_word :
    (ra == REG_GSTAT_LO) ? gstat64[31:0] :
    (ra == REG_GSTAT_HI) ? gstat64[63:32] :
    (ra == REG_BASE) ? base_r :
    (ra == REG_INDEX) ? index_r :
    (ra == REG_ABSMAX) ? absmax_r :
    (ra == REG_THRESH) ? thresh_r :
    (ra == REG_STATUS) ? {30'h0, long_r, (state_r != ST_IDLE)} :
    32'h0;

  // Trigger qualification
  wire buf_full = (index_r == absmax_r);
  wire evt_hit = evt_valid && evt_is_precise
                 && precise_sampling_enable_r[evt_counter];
  wire trigger = evt_hit && (state_r == ST_IDLE) && !buf_full;

  // Index after this record and threshold match
  wire [31:0] index_adv = index_r + {24'h0, rec_len};
  wire thresh_hit = (state_r == ST_ADV) && (index_adv == thresh_r);
  wire mem_acc = mem_req_r && mem_ready;
  wire [2:0] slot_inc = slot_r + 3'h1;

  // Mode fitted register values
  wire [63:0] fit_bp, fit_sp, fit_x1, fit_dla;

  pewr_slot_fit #(.LEGACY_EXISTS(1'b1)) u_fit_bp (
    .long_mode(core_long_mode),
    .value(base_pointer_register),
    .slot(fit_bp)
  );
  pewr_slot_fit #(.LEGACY_EXISTS(1'b1)) u_fit_sp (
    .long_mode(core_long_mode),
    .value(stack_pointer_register),
    .slot(fit_sp)
  );
  pewr_slot_fit #(.LEGACY_EXISTS(1'b0)) u_fit_x1 (
    .long_mode(core_long_mode),
    .value(first_extended_register),
    .slot(fit_x1)
  );
  pewr_slot_fit #(.LEGACY_EXISTS(1'b1)) u_fit_dla (
    .long_mode(core_long_mode),
    .value(data_linear_addr),
    .slot(fit_dla)
  );

  // Overflow flags, buffer overflow set at threshold
  wire [NCNT:0] gs_set = {thresh_hit, ctr_overflow};
  wire [NCNT:0] gs_clr = {w_ghi & hwdata[GSTAT_BUFOVF_BIT-32],
                          {NCNT{w_glo}} & hwdata[NCNT-1:0]};

  pewr_sticky #(.W(NCNT+1)) u_gstat (
    .hclk(hclk),
    .hresetn(hresetn),
    .set(gs_set),
    .clr(gs_clr),
    .q(gstat_q)
  );

  // Writer next state
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: if (trigger) state_nxt = ST_LOAD;
      ST_LOAD: state_nxt = ST_WRITE;
      ST_WRITE: if (mem_acc && (slot_r == slot_last)) state_nxt = ST_ADV;
      ST_ADV: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  // Bus slave registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h0;
      hrdata_r <= 32'h0;
    end
    else
    begin
      wr_pend_r <= wr_take;
      if (wr_take) wr_addr_r <= ra;
      if (rd_take) hrdata_r <= rd_mux;
    end
  end

  // Software registers; a software index write wins over the advance
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      precise_sampling_enable_r <= '0;
      base_r <= RST_ADDR;
      index_r <= RST_ADDR;
      absmax_r <= RST_ADDR;
      thresh_r <= RST_ADDR;
    end
    else
    begin
      if (w_en) precise_sampling_enable_r <= hwdata[NCNT-1:0];
      if (w_base) base_r <= hwdata;
      if (w_max) absmax_r <= hwdata;
      if (w_thr) thresh_r <= hwdata;
      if (w_idx) index_r <= hwdata;
      else if (state_r == ST_ADV) index_r <= index_adv;
    end
  end

  // Capture of record contents at the trigger
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      long_r <= 1'b0;
      for (int i = 0; i < SLOT_NUM; i++) slot_data_r[i] <= RST_WORD;
    end
    else if (trigger)
    begin
      long_r <= core_long_mode;
      slot_data_r[0] <= fit_bp;
      slot_data_r[1] <= fit_sp;
      slot_data_r[2] <= fit_x1;
      slot_data_r[3] <= gstat64;
      slot_data_r[4] <= fit_dla;
      slot_data_r[5] <= data_source;
      slot_data_r[6] <= load_latency;
    end
  end

  // Writer state, memory port and interrupt pulse
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_r <= ST_IDLE;
      slot_r <= 3'h0;
      mem_req_r <= 1'b0;
      mem_addr_r <= RST_ADDR;
      mem_wdata_r <= RST_WORD;
      perf_irq_r <= 1'b0;
      busy_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      perf_irq_r <= thresh_hit;
      busy_r <= (state_nxt != ST_IDLE);
      if (state_r == ST_LOAD)
      begin
        slot_r <= 3'h0;
        mem_req_r <= 1'b1;
        mem_addr_r <= index_r + {24'h0, REC_SLOT_OFF[0]};
        mem_wdata_r <= slot_data_r[0];
      end
      else if (mem_acc && (slot_r == slot_last))
        mem_req_r <= 1'b0;
      else if (mem_acc)
      begin
        slot_r <= slot_inc;
        mem_addr_r <= index_r + {24'h0, REC_SLOT_OFF[slot_inc]};
        mem_wdata_r <= slot_data_r[slot_inc];
      end
    end
  end

  // Outputs
  assign hrdata = hrdata_r;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign mem_req = mem_req_r;
  assign mem_addr = mem_addr_r;
  assign mem_wdata = mem_wdata_r;
  assign perf_irq = perf_irq_r;
  assign assist_busy = busy_r;

  // Checks
  a_full_no_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_r == ST_IDLE && buf_full && !w_idx) |=> (state_r == ST_IDLE && !mem_req_r))
    else $error("record started with a full buffer");
  a_plain_event_ignored: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_r == ST_IDLE && !(evt_valid && evt_is_precise)) |=> (state_r == ST_IDLE))
    else $error("non precise event started a record");
  a_legacy_upper_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (mem_req_r && !long_r && slot_r <= 3'h1) |-> (mem_wdata_r[63:32] == 32'h0))
    else $error("upper half not zero outside long mode");
  a_absent_reg_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (mem_req_r && !long_r && mem_addr_r == index_r + 32'h50) |-> (mem_wdata_r == 64'h0))
    else $error("absent register not written as zero");
  a_long_full_width: assert property (@(posedge hclk) disable iff (!hresetn)
    (trigger && core_long_mode) |=> (slot_data_r[0] == $past(base_pointer_register)))
    else $error("long mode value not stored whole");
  a_cap_field_read: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_take && ra == REG_CAP && ENHANCED) |=> (hrdata[11:8] == 4'h1))
    else $error("capability format field wrong");
  a_status_snapshot: assert property (@(posedge hclk) disable iff (!hresetn)
    trigger |=> (slot_data_r[3][NCNT-1:0] == $past(gstat_q[NCNT-1:0])))
    else $error("overflow snapshot not taken before assist");
  a_index_advance: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_r == ST_ADV && !w_idx) |=> (index_r == $past(index_r) + {24'h0, $past(rec_len)}))
    else $error("index did not advance by one record");
  a_thresh_irq: assert property (@(posedge hclk) disable iff (!hresetn)
    thresh_hit |=> (perf_irq && gstat_q[NCNT]))
    else $error("threshold did not raise interrupt and overflow bit");
  a_basic_short: assert property (@(posedge hclk) disable iff (!hresetn)
    (mem_req_r && !enh) |-> (mem_addr_r - index_r < 32'h90))
    else $error("enhanced tail written in basic format");

endmodule

// *** test/pewr_mem_model.sv ***
// System memory behind the writer, can answer promptly or slowly
module pewr_mem_model
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Write port from the writer
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic [63:0] mem_wdata,
  output logic mem_ready,
  // Stall control from the bench
  input wire logic slow
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] mem [logic [31:0]];
  int wr_count;

  // Accept a word on a request edge, stall every other cycle when slow
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mem_ready <= 1'b0;
      wr_count <= 0;
    end
    else
    begin
      if (mem_req && mem_ready)
      begin
        mem[mem_addr] = mem_wdata;
        wr_count <= wr_count + 1;
      end
      mem_ready <= slow ? !mem_ready : 1'b1;
    end
  end
endmodule

// *** test/test_precise_event_record_writer.sv ***
module test_precise_event_record_writer;
  import pewr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, mem_addr;
  logic [1:0] htrans, evt_counter;
  logic [2:0] hsize;
  logic [3:0] ctr_overflow;
  logic core_long_mode, evt_valid, evt_is_precise, mem_req, mem_ready, perf_irq;
  logic assist_busy, slow;
  logic [31:0] hrdata_b, mem_addr_b;
  logic hreadyout_b, hresp_b, mem_req_b, mem_ready_b, perf_irq_b, assist_busy_b;
  logic [63:0] mem_wdata_b;
  logic [63:0] bp, sp, x1, dla, dsrc, lat, mem_wdata;
  int err_count, compares, irq_cnt;
  assign hready = hreadyout;

  // Device and memory
  pewr_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .core_long_mode(core_long_mode),
    .ctr_overflow(ctr_overflow), .evt_valid(evt_valid), .evt_is_precise(evt_is_precise),
    .evt_counter(evt_counter), .base_pointer_register(bp), .stack_pointer_register(sp),
    .first_extended_register(x1), .data_linear_addr(dla), .data_source(dsrc),
    .load_latency(lat), .mem_req(mem_req), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ready(mem_ready), .perf_irq(perf_irq), .assist_busy(assist_busy));
  pewr_mem_model mem_u (.hclk(hclk), .hresetn(hresetn), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ready(mem_ready), .slow(slow));

  // Basic format device on the same bus and events, with a memory of its own
  pewr_top #(.ENHANCED(1'b0)) dut_b (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata_b), .hreadyout(hreadyout_b), .hresp(hresp_b),
    .core_long_mode(core_long_mode), .ctr_overflow(ctr_overflow), .evt_valid(evt_valid),
    .evt_is_precise(evt_is_precise), .evt_counter(evt_counter),
    .base_pointer_register(bp), .stack_pointer_register(sp),
    .first_extended_register(x1), .data_linear_addr(dla), .data_source(dsrc),
    .load_latency(lat), .mem_req(mem_req_b), .mem_addr(mem_addr_b),
    .mem_wdata(mem_wdata_b), .mem_ready(mem_ready_b), .perf_irq(perf_irq_b),
    .assist_busy(assist_busy_b));
  pewr_mem_model mem_b (.hclk(hclk), .hresetn(hresetn), .mem_req(mem_req_b),
    .mem_addr(mem_addr_b), .mem_wdata(mem_wdata_b), .mem_ready(mem_ready_b), .slow(slow));

  // Clock, 4 ns period
  initial
  begin
    hclk = 1'b0;
    forever #2 hclk = !hclk;
  end

  // Interrupt pulse counter
  always @(posedge hclk)
  begin
    if (perf_irq === 1'b1)
      irq_cnt++;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Single AHB transfer: address phase, then data phase
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    chk({32'h0, r}, {32'h0, e});
  endtask

  // One event pulse, then wait for the writer to go idle
  task automatic fire(input logic [1:0] c, input logic p);
    @(posedge hclk);
    evt_valid <= 1'b1;
    evt_counter <= c;
    evt_is_precise <= p;
    @(posedge hclk);
    evt_valid <= 1'b0;
    repeat (3) @(posedge hclk);
    for (int i = 0; i < 200 && assist_busy !== 1'b0; i++)
      @(posedge hclk);
    if (assist_busy !== 1'b0)
    begin
      err_count++;
      $display("MISMATCH t=%0t writer stuck busy", $time);
    end
  endtask

  function automatic logic [63:0] fit(input logic [63:0] v, input logic lm);
    return lm ? v : {32'h0, v[31:0]};
  endfunction

  // Compare every slot of one record in memory
  task automatic chk_rec(input logic [31:0] b, input logic lm, input logic [63:0] snap);
    chk(mem_u.mem[b + REC_BP_OFF], fit(bp, lm));
    chk(mem_u.mem[b + REC_SP_OFF], fit(sp, lm));
    chk(mem_u.mem[b + REC_X1_OFF], lm ? x1 : 64'h0);
    chk(mem_u.mem[b + 32'h90], snap);
    chk(mem_u.mem[b + 32'h98], fit(dla, lm));
    chk(mem_u.mem[b + 32'ha0], dsrc);
    chk(mem_u.mem[b + 32'ha8], lat);
  endtask

  // Capability field and an unmapped address
  task automatic t_cap;
    rd_chk(8'h04, 32'h0000_0100);
    chk(hrdata_b, 32'h0);
    chk(hresp, 1'b0);
    chk(hreadyout, 1'b1);
    rd_chk(8'h40, 32'h0);
  endtask

  // Long mode record with slow memory, overflow snapshot and threshold
  task automatic t_long;
    wr(8'h00, 32'h1);
    wr(8'h10, 32'h1000);
    wr(8'h14, 32'h1000);
    wr(8'h18, 32'h1160);
    wr(8'h1c, 32'h10b0);
    @(posedge hclk);
    ctr_overflow <= 4'b0101;
    @(posedge hclk);
    ctr_overflow <= 4'b0000;
    slow <= 1'b1;
    core_long_mode <= 1'b1;
    fire(2'd0, 1'b1);
    chk_rec(32'h1000, 1'b1, 64'h5);
    rd_chk(8'h14, 32'h10b0);
    chk(hrdata_b, 32'h1090);
    chk(irq_cnt, 1);
    rd_chk(8'h0c, 32'h4000_0000);
    chk(hrdata_b, 32'h0);
    chk(mem_u.wr_count, 7);
    chk(mem_b.wr_count, 3);
    chk(mem_b.mem[32'h1000 + REC_X1_OFF], x1);
  endtask

  // Non-precise event and a disabled counter write nothing
  task automatic t_refuse;
    fire(2'd0, 1'b0);
    fire(2'd1, 1'b1);
    chk(mem_u.wr_count, 7);
    chk(mem_b.wr_count, 3);
    chk(assist_busy, 1'b0);
  endtask

  // Short mode record fills the enhanced buffer, its further events are dropped; the basic device keeps writing
  task automatic t_short;
    slow <= 1'b0;
    core_long_mode <= 1'b0;
    fire(2'd0, 1'b1);
    chk_rec(32'h10b0, 1'b0, 64'h4000_0000_0000_0005);
    rd_chk(8'h14, 32'h1160);
    chk(hrdata_b, 32'h1120);
    chk(mem_b.wr_count, 6);
    chk(mem_b.mem[32'h1090 + REC_BP_OFF], {32'h0, bp[31:0]});
    chk(irq_cnt, 1);
    fire(2'd0, 1'b1);
    chk(mem_u.wr_count, 14);
    chk(irq_cnt, 1);
    repeat (8) @(posedge hclk);
    chk(mem_b.wr_count, 9);
  endtask

  // Watchdog
  initial
  begin
    #200000;
    err_count++;
    results();
  end

  initial
  begin
    hresetn = 1'b0;
    {hsel, hwrite, evt_valid, evt_is_precise, core_long_mode, slow} = '0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'b00;
    hsize = 3'h2;
    evt_counter = 2'd0;
    ctr_overflow = 4'h0;
    bp = 64'h1111_2222_3333_4444;
    sp = 64'h5555_6666_7777_8888;
    x1 = 64'h9999_aaaa_bbbb_cccc;
    dla = 64'hdddd_eeee_ffff_0123;
    dsrc = 64'h0000_0000_0000_0042;
    lat = 64'h0000_0000_0000_0107;
    err_count = 0;
    compares = 0;
    irq_cnt = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_cap();
    t_long();
    t_refuse();
    t_short();
    results();
  end
endmodule
